// ==== rfa_regs.svh ====
`ifndef RFA_REGS_SVH
`define RFA_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets of the register words.
`define RFA_OFF_CTRL        8'h00
`define RFA_OFF_STATUS      8'h04
`define RFA_OFF_CMD         8'h08
`define RFA_OFF_W1C         8'h0c
`define RFA_OFF_WAC         8'h10
`define RFA_OFF_COR         8'h14
`define RFA_OFF_LATCH       8'h18
`define RFA_OFF_PULSE       8'h1c
`define RFA_OFF_KEEP        8'h20
`define RFA_OFF_INDEX       8'h24
`define RFA_OFF_DATA        8'h28

////////////////////////////////////////////////////////////////////////////////
// Field positions.
`define RFA_CTRL_SRST_BIT   8
`define RFA_STAT_SRST_BIT   16
`define RFA_LATCH_LL_LSB    8
`define RFA_PULSE_GO_BIT    0
`define RFA_PULSE_SS_BIT    1

////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define RFA_CTRL_RST        8'h00
`define RFA_KEEP_RST        8'h00
`define RFA_FLAG_RST        8'h00
`define RFA_LL_RST          8'hff
`define RFA_BIT0_RST        1'h0
`define RFA_BIT1_RST        1'h1
`define RFA_IDX_RST         4'h0
`define RFA_CMD_RST         8'h00

`endif

// ==== rfa_pkg.sv ====
package rfa_pkg;

	typedef enum logic [2:0] {
		RFA_RW  = 3'h0,
		RFA_W1C = 3'h1,
		RFA_WAC = 3'h2,
		RFA_COR = 3'h3,
		RFA_LH  = 3'h4,
		RFA_LL  = 3'h5,
		RFA_SC  = 3'h6,
		RFA_SS  = 3'h7
	} rfa_mode_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} rfa_avs_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} rfa_avs_rsp_t;

	typedef struct packed {
		logic             rd_done;
		logic [31:0]      rdata;
		logic [7:0]       cmd;
		logic             cmd_stb;
		logic [3:0]       index;
		logic [15:0][31:0] fabric;
	} rfa_bank_t;

endpackage

// ==== rfa_field.sv ====
`timescale 1ns/1ps

module rfa_field #(
	parameter int                 W      = 8,
	parameter rfa_pkg::rfa_mode_t MODE   = rfa_pkg::RFA_RW,
	parameter logic [W-1:0]       RST    = '0,
	parameter bit                 IMMUNE = 1'b0
) (
	// Clock and resets.
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic         soft_rst,
	// Software access.
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wr_mask,
	input  wire logic [W-1:0] wr_data,
	input  wire logic [W-1:0] rd_clr,
	// Hardware side.
	input  wire logic [W-1:0] hw_in,
	output logic      [W-1:0] value
);

	typedef struct packed {
		logic [W-1:0] val;
	} rfa_cell_t;

	rfa_cell_t q_r;
	rfa_cell_t q_nxt;

	// Hardware sets are applied after write and read clears, so only a reset, hard or soft, can drop an event.
	always_comb begin
		q_nxt = q_r;
		unique case (MODE)
			rfa_pkg::RFA_RW: begin
				if (wr_en) begin
					q_nxt.val = (q_r.val & ~wr_mask) | (wr_data & wr_mask);
				end
			end
			rfa_pkg::RFA_W1C: begin
				if (wr_en) begin
					q_nxt.val = q_r.val & ~(wr_data & wr_mask); // R3
				end
				q_nxt.val = q_nxt.val | hw_in;
			end
			rfa_pkg::RFA_WAC: begin
				q_nxt.val = (wr_en ? '0 : q_r.val) | hw_in; // R4
			end
			rfa_pkg::RFA_COR: begin
				q_nxt.val = (q_r.val & ~rd_clr) | hw_in; // R5
			end
			rfa_pkg::RFA_LH: begin
				q_nxt.val = (q_r.val & ~rd_clr) | hw_in; // R9 R10
			end
			rfa_pkg::RFA_LL: begin
				q_nxt.val = (q_r.val | rd_clr) & hw_in; // R6
			end
			rfa_pkg::RFA_SC: begin
				q_nxt.val = wr_en ? (wr_data & wr_mask) : '0; // R7
			end
			rfa_pkg::RFA_SS: begin
				q_nxt.val = wr_en ? ~(~wr_data & wr_mask) : '1; // R8
			end
		endcase
		if (soft_rst && !IMMUNE) begin
			q_nxt.val = RST; // R11
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_r.val <= RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign value = q_r.val;

endmodule

// ==== rfa_bank.sv ====
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`include "rfa_regs.svh"

// Summary of operation
// [R1] A read-only field returns its current value and ignores writes.
// [R2] A write-only field takes writes while its read data carries no meaning.
// [R3] Writing one to a write-one-to-clear bit clears it; zero leaves it.
// [R4] Any write to a write-anything-to-clear field clears the whole field.
// [R5] A clear-on-read field clears after a read returns it, ignoring writes.
// [R6] A latch-low flag holds a low condition until the register is read.
// [R7] A self-clearing bit drops to zero by itself; writing zero does nothing.
// [R8] A self-setting bit returns to one by itself; writing one does nothing.
// [R9] A latch-high bit holds until read and then follows its condition.
// [R10] An unread latch-high bit stays high even when its condition ends.
// [R11] Soft-reset-immune bits keep their state through a software reset.
// [R12] Software writes zero to reserved bits and ignores their read value.
// [R13] Fabric registers are reached only through an index and data pair.
// [R14] Read-triggered clears act after the read data is captured.
module rfa_bank (
	// Clock and reset.
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  sw_reset,
	// Register bus.
	input  wire rfa_pkg::rfa_avs_req_t avs_req,
	output rfa_pkg::rfa_avs_rsp_t      avs_rsp,
	// Hardware conditions.
	input  wire logic [15:0]           live_status,
	input  wire logic [7:0]            evt_w1c,
	input  wire logic [7:0]            evt_wac,
	input  wire logic [7:0]            evt_cor,
	input  wire logic [7:0]            hi_cond,
	input  wire logic [7:0]            lo_cond,
	// Controls driven by software.
	output logic      [7:0]            ctrl_out,
	output logic      [7:0]            keep_out,
	output logic      [7:0]            cmd_out,
	output logic                       cmd_strobe,
	output logic                       go_pulse,
	output logic                       ss_level,
	output logic                       soft_reset_active,
	output logic      [31:0]           fab_cfg0
);

	rfa_pkg::rfa_bank_t q_r;
	rfa_pkg::rfa_bank_t q_nxt;

	logic [31:0] be_mask;
	logic [31:0] rmux;
	logic        rd_acc;
	logic        wr_acc;
	logic        soft_rst;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        hit_cmd;
	logic        hit_w1c;
	logic        hit_wac;
	logic        hit_cor;
	logic        hit_latch;
	logic        hit_pulse;
	logic        hit_keep;
	logic        hit_index;
	logic        hit_data;
	logic [7:0]  ctrl_q;
	logic [0:0]  srst_q;
	logic [7:0]  w1c_q;
	logic [7:0]  wac_q;
	logic [7:0]  cor_q;
	logic [7:0]  lh_q;
	logic [7:0]  ll_q;
	logic [0:0]  go_q;
	logic [0:0]  ss_q;
	logic [7:0]  keep_q;
	logic [7:0]  cor_clr;
	logic [7:0]  lh_clr;
	logic [7:0]  ll_clr;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode. Writes finish in their first cycle; reads stall one cycle
	// so that read data always comes from a flip-flop.
	always_comb begin
		be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
			{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
		hit_ctrl  = avs_req.address == `RFA_OFF_CTRL;
		hit_stat  = avs_req.address == `RFA_OFF_STATUS;
		hit_cmd   = avs_req.address == `RFA_OFF_CMD;
		hit_w1c   = avs_req.address == `RFA_OFF_W1C;
		hit_wac   = avs_req.address == `RFA_OFF_WAC;
		hit_cor   = avs_req.address == `RFA_OFF_COR;
		hit_latch = avs_req.address == `RFA_OFF_LATCH;
		hit_pulse = avs_req.address == `RFA_OFF_PULSE;
		hit_keep  = avs_req.address == `RFA_OFF_KEEP;
		hit_index = avs_req.address == `RFA_OFF_INDEX;
		hit_data  = avs_req.address == `RFA_OFF_DATA;
	end

	assign avs_rsp.waitrequest = avs_req.read & ~q_r.rd_done;
	assign avs_rsp.readdata    = q_r.rdata;
	assign rd_acc   = avs_req.read & q_r.rd_done;
	assign wr_acc   = avs_req.write;
	assign soft_rst = sw_reset | srst_q[0];

	// Only bits that were actually reported are cleared.
	assign cor_clr = (rd_acc && hit_cor) ? q_r.rdata[7:0] : 8'h00; // R14
	assign lh_clr  = (rd_acc && hit_latch) ? q_r.rdata[7:0] : 8'h00; // R14
	assign ll_clr  = (rd_acc && hit_latch) ?
		~q_r.rdata[`RFA_LATCH_LL_LSB +: 8] : 8'h00; // R14

	////////////////////////////////////////////////////////////////////////////
	// Field cells.
	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_RW), .RST(`RFA_CTRL_RST),
		.IMMUNE(1'b0)) u_ctrl (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_ctrl), .wr_mask(be_mask[7:0]),
		.wr_data(avs_req.writedata[7:0]), .rd_clr(8'h00),
		.hw_in(8'h00), .value(ctrl_q));

	rfa_field #(.W(1), .MODE(rfa_pkg::RFA_SC), .RST(`RFA_BIT0_RST),
		.IMMUNE(1'b0)) u_srst (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_ctrl),
		.wr_mask(be_mask[`RFA_CTRL_SRST_BIT +: 1]),
		.wr_data(avs_req.writedata[`RFA_CTRL_SRST_BIT +: 1]),
		.rd_clr(1'h0), .hw_in(1'h0), .value(srst_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_W1C), .RST(`RFA_FLAG_RST),
		.IMMUNE(1'b0)) u_w1c (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_w1c), .wr_mask(be_mask[7:0]),
		.wr_data(avs_req.writedata[7:0]), .rd_clr(8'h00),
		.hw_in(evt_w1c), .value(w1c_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_WAC), .RST(`RFA_FLAG_RST),
		.IMMUNE(1'b0)) u_wac (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_wac), .wr_mask(be_mask[7:0]),
		.wr_data(avs_req.writedata[7:0]), .rd_clr(8'h00),
		.hw_in(evt_wac), .value(wac_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_COR), .RST(`RFA_FLAG_RST),
		.IMMUNE(1'b0)) u_cor (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(1'b0), .wr_mask(8'h00), .wr_data(8'h00),
		.rd_clr(cor_clr), .hw_in(evt_cor), .value(cor_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_LH), .RST(`RFA_FLAG_RST),
		.IMMUNE(1'b0)) u_lh (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(1'b0), .wr_mask(8'h00), .wr_data(8'h00),
		.rd_clr(lh_clr), .hw_in(hi_cond), .value(lh_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_LL), .RST(`RFA_LL_RST),
		.IMMUNE(1'b0)) u_ll (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(1'b0), .wr_mask(8'h00), .wr_data(8'h00),
		.rd_clr(ll_clr), .hw_in(lo_cond), .value(ll_q));

	rfa_field #(.W(1), .MODE(rfa_pkg::RFA_SC), .RST(`RFA_BIT0_RST),
		.IMMUNE(1'b0)) u_go (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_pulse),
		.wr_mask(be_mask[`RFA_PULSE_GO_BIT +: 1]),
		.wr_data(avs_req.writedata[`RFA_PULSE_GO_BIT +: 1]),
		.rd_clr(1'h0), .hw_in(1'h0), .value(go_q));

	rfa_field #(.W(1), .MODE(rfa_pkg::RFA_SS), .RST(`RFA_BIT1_RST),
		.IMMUNE(1'b0)) u_ss (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_pulse),
		.wr_mask(be_mask[`RFA_PULSE_SS_BIT +: 1]),
		.wr_data(avs_req.writedata[`RFA_PULSE_SS_BIT +: 1]),
		.rd_clr(1'h0), .hw_in(1'h0), .value(ss_q));

	rfa_field #(.W(8), .MODE(rfa_pkg::RFA_RW), .RST(`RFA_KEEP_RST),
		.IMMUNE(1'b1)) u_keep (
		.ref_clk(ref_clk), .reset(reset), .soft_rst(soft_rst),
		.wr_en(wr_acc && hit_keep), .wr_mask(be_mask[7:0]),
		.wr_data(avs_req.writedata[7:0]), .rd_clr(8'h00),
		.hw_in(8'h00), .value(keep_q));

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer. Reserved bits and unmapped words read as zero.
	always_comb begin
		rmux = 32'h0000_0000;
		if (hit_ctrl) begin
			rmux[7:0] = ctrl_q;
			rmux[`RFA_CTRL_SRST_BIT] = srst_q[0]; // R7
		end
		if (hit_stat) begin
			rmux[15:0] = live_status; // R1
			rmux[`RFA_STAT_SRST_BIT] = soft_rst;
		end
		if (hit_w1c) begin
			rmux[7:0] = w1c_q;
		end
		if (hit_wac) begin
			rmux[7:0] = wac_q;
		end
		if (hit_cor) begin
			rmux[7:0] = cor_q;
		end
		if (hit_latch) begin
			rmux[7:0] = lh_q;
			rmux[`RFA_LATCH_LL_LSB +: 8] = ll_q;
		end
		if (hit_pulse) begin
			rmux[`RFA_PULSE_GO_BIT] = go_q[0];
			rmux[`RFA_PULSE_SS_BIT] = ss_q[0];
		end
		if (hit_keep) begin
			rmux[7:0] = keep_q;
		end
		if (hit_index) begin
			rmux[3:0] = q_r.index;
		end
		if (hit_data) begin
			rmux = q_r.fabric[q_r.index]; // R13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bank state: read capture, write-only command, indirect fabric window.
	always_comb begin
		q_nxt = q_r;
		q_nxt.rd_done = avs_req.read & ~q_r.rd_done;
		q_nxt.cmd_stb = 1'b0;
		if (avs_req.read && !q_r.rd_done) begin
			q_nxt.rdata = rmux; // R14
		end
		if (wr_acc && hit_cmd && avs_req.byteenable[0]) begin
			q_nxt.cmd     = avs_req.writedata[7:0]; // R2
			q_nxt.cmd_stb = 1'b1;
		end
		if (wr_acc && hit_index && avs_req.byteenable[0]) begin
			q_nxt.index = avs_req.writedata[3:0]; // R13
		end
		if (wr_acc && hit_data) begin
			q_nxt.fabric[q_r.index] = (q_r.fabric[q_r.index] & ~be_mask) |
				(avs_req.writedata & be_mask); // R13
		end
		if (soft_rst) begin
			q_nxt.cmd     = `RFA_CMD_RST;
			q_nxt.cmd_stb = 1'b0;
			q_nxt.index   = `RFA_IDX_RST;
			q_nxt.fabric  = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign ctrl_out          = ctrl_q;
	assign keep_out          = keep_q;
	assign cmd_out           = q_r.cmd;
	assign cmd_strobe        = q_r.cmd_stb;
	assign go_pulse          = go_q[0];
	assign ss_level          = ss_q[0];
	assign soft_reset_active = srst_q[0];
	assign fab_cfg0          = q_r.fabric[0];

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	status_read_a: assert property ( // R1
		rd_acc && hit_stat |-> avs_rsp.readdata[15:0] == $past(live_status))
		else $error("status read does not show live status");

	wo_read_a: assert property ( // R2
		rd_acc && hit_cmd |-> avs_rsp.readdata == 32'h0000_0000)
		else $error("write-only word read not zero");

	w1c_clear_a: assert property ( // R3
		wr_acc && hit_w1c |=> (w1c_q & $past(avs_req.writedata[7:0] &
		be_mask[7:0] & ~evt_w1c)) == 8'h00)
		else $error("write-one did not clear flag");

	w1c_keep_a: assert property ( // R3
		wr_acc && hit_w1c && !soft_rst |=> (w1c_q & $past(w1c_q &
		~(avs_req.writedata[7:0] & be_mask[7:0]))) == $past(w1c_q &
		~(avs_req.writedata[7:0] & be_mask[7:0])))
		else $error("write-zero changed flag");

	wac_clear_a: assert property ( // R4
		wr_acc && hit_wac && !soft_rst |=> wac_q == $past(evt_wac))
		else $error("write-any did not clear field");

	cor_value_a: assert property ( // R14
		rd_acc && hit_cor |-> avs_rsp.readdata[7:0] == $past(cor_q))
		else $error("clear-on-read returned cleared value");

	cor_clear_a: assert property ( // R5
		rd_acc && hit_cor |=> (cor_q & $past(avs_rsp.readdata[7:0] &
		~evt_cor)) == 8'h00)
		else $error("clear-on-read did not clear");

	lh_hold_a: assert property ( // R10
		!(rd_acc && hit_latch) && !soft_rst |=> ($past(lh_q) & ~lh_q) == 8'h00)
		else $error("unread latch-high bit dropped");

	lh_follow_a: assert property ( // R9
		rd_acc && hit_latch && !soft_rst |=> lh_q == ($past(hi_cond) |
		($past(lh_q) & ~$past(avs_rsp.readdata[7:0]))))
		else $error("latch-high bit did not follow condition");

	ll_hold_a: assert property ( // R6
		!(rd_acc && hit_latch) && !soft_rst |=> (~$past(ll_q) & ll_q) == 8'h00)
		else $error("unread latch-low bit rose");

	sc_self_a: assert property ( // R7
		!(wr_acc && hit_pulse) |=> !go_q[0])
		else $error("self-clearing bit did not clear");

	ss_self_a: assert property ( // R8
		!(wr_acc && hit_pulse) |=> ss_q[0])
		else $error("self-setting bit did not set");

	keep_soft_a: assert property ( // R11
		soft_rst && !(wr_acc && hit_keep) |=> $stable(keep_q))
		else $error("immune field changed on soft reset");

	indirect_wr_a: assert property ( // R13
		wr_acc && hit_data && avs_req.byteenable == 4'hf && !soft_rst |=>
		q_r.fabric[$past(q_r.index)] == $past(avs_req.writedata))
		else $error("indirect write lost");

	cor_read_c: cover property (rd_acc && hit_cor && cor_q != 8'h00);
	lh_read_c: cover property (rd_acc && hit_latch && lh_q != hi_cond);
	w1c_write_c: cover property (wr_acc && hit_w1c && w1c_q != 8'h00);
	soft_rst_c: cover property (soft_rst && keep_q != `RFA_KEEP_RST);

endmodule

// ==== tb_rfa_bank.sv ====
`timescale 1ns/1ps
`include "rfa_regs.svh"

module tb_rfa_bank;

	localparam int LIMIT = 5000;

	logic                  ref_clk;
	logic                  reset;
	logic                  sw_reset;
	rfa_pkg::rfa_avs_req_t avs_req;
	rfa_pkg::rfa_avs_rsp_t avs_rsp;
	logic [15:0]           live_status;
	logic [7:0]            evt_w1c;
	logic [7:0]            evt_wac;
	logic [7:0]            evt_cor;
	logic [7:0]            hi_cond;
	logic [7:0]            lo_cond;
	logic [7:0]            ctrl_out;
	logic [7:0]            keep_out;
	logic [7:0]            cmd_out;
	logic                  cmd_strobe;
	logic                  go_pulse;
	logic                  ss_level;
	logic                  soft_reset_active;
	logic [31:0]           fab_cfg0;
	int                    mismatches;
	int                    total_checks;
	int                    cycles;

	rfa_bank u_dut (
		.ref_clk           (ref_clk),
		.reset             (reset),
		.sw_reset          (sw_reset),
		.avs_req           (avs_req),
		.avs_rsp           (avs_rsp),
		.live_status       (live_status),
		.evt_w1c           (evt_w1c),
		.evt_wac           (evt_wac),
		.evt_cor           (evt_cor),
		.hi_cond           (hi_cond),
		.lo_cond           (lo_cond),
		.ctrl_out          (ctrl_out),
		.keep_out          (keep_out),
		.cmd_out           (cmd_out),
		.cmd_strobe        (cmd_strobe),
		.go_pulse          (go_pulse),
		.ss_level          (ss_level),
		.soft_reset_active (soft_reset_active),
		.fab_cfg0          (fab_cfg0)
	);

	always #20 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// The request is held until an edge samples waitrequest low.
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge ref_clk);
		avs_req.address <= a;
		avs_req.byteenable <= be;
		avs_req.writedata <= d;
		avs_req.write <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (avs_rsp.waitrequest !== 1'b0);
		avs_req.write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
		input string name);
		logic [31:0] d;
		@(posedge ref_clk);
		avs_req.address <= a;
		avs_req.read <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (avs_rsp.waitrequest !== 1'b0);
		d = avs_rsp.readdata;
		avs_req.read <= 1'b0;
		check(name, d, exp);
	endtask

	task automatic edge_then_settle();
		@(posedge ref_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk(`RFA_OFF_CTRL, 32'h00000000, "ctrl reset");
		rd_chk(`RFA_OFF_PULSE, 32'h00000002, "pulse reset");
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff00, "latch reset");
		check("ss reset", {31'h0, ss_level}, 32'h00000001);
	endtask

	task automatic t_ro();
		bus_write(`RFA_OFF_STATUS, 32'hffffffff, 4'hf);
		rd_chk(`RFA_OFF_STATUS, 32'h0000a5c3, "status");
		@(posedge ref_clk);
		live_status <= 16'h3c5a;
		rd_chk(`RFA_OFF_STATUS, 32'h00003c5a, "status live");
	endtask

	task automatic t_wo();
		bus_write(`RFA_OFF_CMD, 32'h0000005a, 4'h1);
		#1;
		check("cmd strobe", {31'h0, cmd_strobe}, 32'h00000001);
		check("cmd out", {24'h0, cmd_out}, 32'h0000005a);
		edge_then_settle();
		check("cmd strobe end", {31'h0, cmd_strobe}, 32'h00000000);
	endtask

	task automatic t_w1c();
		@(posedge ref_clk);
		evt_w1c <= 8'hff;
		@(posedge ref_clk);
		evt_w1c <= 8'h00;
		bus_write(`RFA_OFF_W1C, 32'h000000ff, 4'h0);
		rd_chk(`RFA_OFF_W1C, 32'h000000ff, "w1c no lanes");
		bus_write(`RFA_OFF_W1C, 32'h0000000f, 4'h1);
		rd_chk(`RFA_OFF_W1C, 32'h000000f0, "w1c half");
	endtask

	task automatic t_wac();
		@(posedge ref_clk);
		evt_wac <= 8'h3c;
		@(posedge ref_clk);
		evt_wac <= 8'h00;
		rd_chk(`RFA_OFF_WAC, 32'h0000003c, "wac set");
		bus_write(`RFA_OFF_WAC, 32'h00000000, 4'h0);
		rd_chk(`RFA_OFF_WAC, 32'h00000000, "wac cleared");
	endtask

	task automatic t_cor();
		@(posedge ref_clk);
		evt_cor <= 8'h81;
		@(posedge ref_clk);
		evt_cor <= 8'h00;
		bus_write(`RFA_OFF_COR, 32'h000000ff, 4'h1);
		rd_chk(`RFA_OFF_COR, 32'h00000081, "cor first");
		rd_chk(`RFA_OFF_COR, 32'h00000000, "cor second");
	endtask

	task automatic t_lh();
		@(posedge ref_clk);
		hi_cond <= 8'h11;
		@(posedge ref_clk);
		hi_cond <= 8'h01;
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff11, "lh held");
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff01, "lh follows");
		@(posedge ref_clk);
		hi_cond <= 8'h00;
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff01, "lh unread");
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff00, "lh gone");
	endtask

	task automatic t_ll();
		@(posedge ref_clk);
		lo_cond <= 8'hfb;
		@(posedge ref_clk);
		lo_cond <= 8'hff;
		rd_chk(`RFA_OFF_LATCH, 32'h0000fb00, "ll held");
		rd_chk(`RFA_OFF_LATCH, 32'h0000ff00, "ll cleared");
	endtask

	task automatic t_pulse();
		bus_write(`RFA_OFF_PULSE, 32'h00000003, 4'h1);
		#1;
		check("go set", {31'h0, go_pulse}, 32'h00000001);
		check("ss one", {31'h0, ss_level}, 32'h00000001);
		edge_then_settle();
		check("go self clear", {31'h0, go_pulse}, 32'h00000000);
		bus_write(`RFA_OFF_PULSE, 32'h00000000, 4'h1);
		#1;
		check("go zero write", {31'h0, go_pulse}, 32'h00000000);
		check("ss cleared", {31'h0, ss_level}, 32'h00000000);
		edge_then_settle();
		check("ss self set", {31'h0, ss_level}, 32'h00000001);
		rd_chk(`RFA_OFF_PULSE, 32'h00000002, "pulse read");
	endtask

	task automatic t_soft();
		bus_write(`RFA_OFF_CTRL, 32'h00000033, 4'h1);
		bus_write(`RFA_OFF_KEEP, 32'h00000044, 4'h1);
		#1;
		check("ctrl out", {24'h0, ctrl_out}, 32'h00000033);
		check("keep out", {24'h0, keep_out}, 32'h00000044);
		@(posedge ref_clk);
		sw_reset <= 1'b1;
		@(posedge ref_clk);
		sw_reset <= 1'b0;
		rd_chk(`RFA_OFF_CTRL, 32'h00000000, "ctrl soft");
		rd_chk(`RFA_OFF_KEEP, 32'h00000044, "keep soft");
		bus_write(`RFA_OFF_CTRL, 32'h00000177, 4'h3);
		#1;
		check("srst bit", {31'h0, soft_reset_active}, 32'h00000001);
		rd_chk(`RFA_OFF_CTRL, 32'h00000000, "ctrl self srst");
		rd_chk(`RFA_OFF_KEEP, 32'h00000044, "keep self srst");
		#1;
		check("ctrl out soft", {24'h0, ctrl_out}, 32'h00000000);
		check("keep out soft", {24'h0, keep_out}, 32'h00000044);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		rd_chk(`RFA_OFF_KEEP, 32'h00000000, "keep hard");
	endtask

	task automatic t_fabric();
		bus_write(`RFA_OFF_INDEX, 32'h00000000, 4'h1);
		bus_write(`RFA_OFF_DATA, 32'hdeadbeef, 4'hf);
		#1;
		check("fabric word0", fab_cfg0, 32'hdeadbeef);
		bus_write(`RFA_OFF_INDEX, 32'h00000005, 4'h1);
		bus_write(`RFA_OFF_DATA, 32'h12345678, 4'hf);
		bus_write(`RFA_OFF_INDEX, 32'h00000000, 4'h1);
		rd_chk(`RFA_OFF_DATA, 32'hdeadbeef, "fabric idx0");
		bus_write(`RFA_OFF_INDEX, 32'h00000005, 4'h1);
		rd_chk(`RFA_OFF_DATA, 32'h12345678, "fabric idx5");
		bus_write(8'h40, 32'hffffffff, 4'hf);
		rd_chk(8'h40, 32'h00000000, "unmapped");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		sw_reset = 1'b0;
		avs_req = '0;
		live_status = 16'ha5c3;
		evt_w1c = 8'h00;
		evt_wac = 8'h00;
		evt_cor = 8'h00;
		hi_cond = 8'h00;
		lo_cond = 8'hff;
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		t_reset();
		t_ro();
		t_wo();
		t_w1c();
		t_wac();
		t_cor();
		t_lh();
		t_ll();
		t_pulse();
		t_soft();
		t_fabric();
		print_verdict();
	end

endmodule
